// >>> dv/rlo_datapath_checker.sv
// concurrent checks on the arithmetic datapath ports
// assumes one clock, reset asynchronous and active low
`timescale 1ns/100ps
`default_nettype none

module rlo_datapath_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire rlo_pkg::rlo_req_t i_req,
  input wire logic o_ready,
  input wire rlo_pkg::rlo_rsp_t o_rsp,
  input wire logic [rlo_pkg::DATA_W-1:0] o_acc,
  input wire logic [rlo_pkg::DATA_W-1:0] o_sec,
  input wire logic o_overflow
);
  wire logic take;
  assign take = i_req.valid && o_ready;
  // ones' complement sum with end-around carry
  function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  and_result_a: assert property (take && i_req.op == rlo_pkg::OP_AND
    |=> o_acc == ($past(o_acc) & $past(i_req.operand))) else $error("and result wrong");
  add_result_a: assert property (take && i_req.op == rlo_pkg::OP_ADD
    |=> o_acc == oc($past(o_acc), $past(i_req.operand))) else $error("add result wrong");
  sub_result_a: assert property (take && i_req.op == rlo_pkg::OP_SUB
    |=> o_acc == oc($past(o_acc), ~$past(i_req.operand))) else $error("sub result wrong");
  skip_ovf_a: assert property (take && i_req.op == rlo_pkg::OP_SKIP_OVF
    |=> o_rsp.skip == $past(o_overflow) && !o_overflow) else $error("overflow skip wrong");
  skip_novf_a: assert property (take && i_req.op == rlo_pkg::OP_SKIP_NOVF
    |=> o_rsp.skip == !$past(o_overflow) && !o_overflow) else $error("no-overflow skip wrong");
  mul_timing_a: assert property (take && i_req.op == rlo_pkg::OP_MUL
    |=> !o_ready [*8] ##1 !o_ready [*8] ##1 (o_rsp.done && o_ready))
    else $error("multiply timing wrong");
  ones_fill_a: assert property (take && i_req.op == rlo_pkg::OP_ONES && i_req.dest[0]
    |=> o_acc == rlo_pkg::WORD_ONES) else $error("ones fill wrong");
  rao_store_a: assert property (take && i_req.op == rlo_pkg::OP_RAO
    |=> o_rsp.mem_we && o_rsp.mem_data == oc($past(i_req.operand), rlo_pkg::WORD_ONE))
    else $error("replace add one wrong");
  mul_c: cover property (take && i_req.op == rlo_pkg::OP_MUL);
  div_c: cover property (take && i_req.op == rlo_pkg::OP_DIV);
  skip_c: cover property (o_rsp.skip);
endmodule : rlo_datapath_checker

bind rlo_datapath rlo_datapath_checker u_rlo_datapath_checker (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_req(i_req), .o_ready(o_ready), .o_rsp(o_rsp), .o_acc(o_acc),
  .o_sec(o_sec), .o_overflow(o_overflow));

`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the arithmetic datapath
// assumes the bench alone stands in for the instruction stream
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  rlo_pkg::rlo_req_t i_req = '0;
  logic o_ready;
  logic o_overflow;
  rlo_pkg::rlo_rsp_t o_rsp;
  logic [15:0] o_acc;
  logic [15:0] o_sec;
  int mismatches = 0;
  int n_compared = 0;
  logic skp;
  logic we;
  logic [15:0] md;
  always #12.5 i_sys_clk = ~i_sys_clk;
  rlo_datapath u_rlo_datapath (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_req(i_req),
    .o_ready(o_ready), .o_rsp(o_rsp), .o_acc(o_acc), .o_sec(o_sec), .o_overflow(o_overflow));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one instruction: present for one take edge, then wait for done
  task automatic run(input rlo_pkg::rlo_op_t op, input logic [15:0] opd, input logic [2:0] d);
    int k;
    k = 0;
    i_req <= '{valid: 1'b1, op: op, operand: opd, dest: d};
    @(posedge i_sys_clk);
    i_req.valid <= 1'b0;
    #1;
    while (o_rsp.done !== 1'b1 && k < 40) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    chk("done", 16'h0001, {15'h0000, o_rsp.done});
    skp = o_rsp.skip;
    we = o_rsp.mem_we;
    md = o_rsp.mem_data;
    @(posedge i_sys_clk);
  endtask : run
  // there is no load op, so memory-to-register transfer preloads a and q
  task automatic ld(input logic [15:0] a, input logic [15:0] q);
    run(rlo_pkg::OP_CPY_MEM, q, 3'h2);
    run(rlo_pkg::OP_CPY_MEM, a, 3'h1);
  endtask : ld
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_arith();
    logic [15:0] a;
    ld(16'h0F0F, 16'h1111);
    run(rlo_pkg::OP_AND, 16'h3C3C, 3'h0);
    chk("and acc", 16'h0C0C, o_acc);
    run(rlo_pkg::OP_XOR, 16'hFFFF, 3'h0);
    chk("xor acc", 16'hF3F3, o_acc);
    run(rlo_pkg::OP_ADD, 16'h0123, 3'h0);
    a = oc(16'hF3F3, 16'h0123);
    chk("add acc", a, o_acc);
    run(rlo_pkg::OP_SUB, 16'h0100, 3'h0);
    a = oc(a, 16'hFEFF);
    chk("sub acc", a, o_acc);
    run(rlo_pkg::OP_ADD_SEC, 16'h2222, 3'h0);
    chk("addsec sec", 16'h3333, o_sec);
    run(rlo_pkg::OP_INC_ACC, 16'hFFFE, 3'h0);
    chk("inc acc", oc(a, 16'hFFFE), o_acc);
    run(rlo_pkg::OP_INC_SEC, 16'h0001, 3'h0);
    chk("inc sec", 16'h3334, o_sec);
    run(rlo_pkg::OP_RAO, 16'h1234, 3'h0);
    chk("rao data", 16'h1235, md);
    chk("rao we", 16'h0001, {15'h0000, we});
    chk("rao ovf", 16'h0000, {15'h0000, o_overflow});
    $display("test arith done");
  endtask : t_arith
  task automatic t_ovf();
    ld(16'h7FFF, 16'h0000);
    run(rlo_pkg::OP_ADD, 16'h0001, 3'h0);
    chk("ovf pos", 16'h0001, {15'h0000, o_overflow});
    run(rlo_pkg::OP_SKIP_NOVF, 16'h0000, 3'h0);
    chk("novf skip", 16'h0000, {15'h0000, skp});
    run(rlo_pkg::OP_SKIP_NOVF, 16'h0000, 3'h0);
    chk("novf skip2", 16'h0001, {15'h0000, skp});
    ld(16'h8000, 16'h0000);
    run(rlo_pkg::OP_ADD, 16'hFFFE, 3'h0);
    chk("ovf neg", 16'h0001, {15'h0000, o_overflow});
    run(rlo_pkg::OP_SKIP_OVF, 16'h0000, 3'h0);
    chk("ovf skip", 16'h0001, {15'h0000, skp});
    chk("ovf clear", 16'h0000, {15'h0000, o_overflow});
    run(rlo_pkg::OP_SKIP_OVF, 16'h0000, 3'h0);
    chk("ovf skip2", 16'h0000, {15'h0000, skp});
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_muldiv();
    ld(16'h1234, 16'h0000);
    run(rlo_pkg::OP_MUL, 16'h0100, 3'h0);
    chk("mul lo", 16'h3400, o_acc);
    chk("mul hi", 16'h0012, o_sec);
    ld(16'hFFFC, 16'h0000);
    run(rlo_pkg::OP_MUL, 16'h0005, 3'h0);
    chk("muln lo", 16'hFFF0, o_acc);
    chk("muln hi", 16'hFFFF, o_sec);
    ld(16'h0064, 16'h0000);
    run(rlo_pkg::OP_DIV, 16'h0007, 3'h0);
    chk("div quo", 16'h000E, o_acc);
    chk("div rem", 16'h0002, o_sec);
    chk("div ovf", 16'h0000, {15'h0000, o_overflow});
    ld(16'hFF9B, 16'hFFFF);
    run(rlo_pkg::OP_DIV, 16'h0007, 3'h0);
    chk("divn quo", 16'hFFF1, o_acc);
    chk("divn rem", 16'hFFFD, o_sec);
    chk("divn ovf", 16'h0000, {15'h0000, o_overflow});
    ld(16'h0000, 16'h0005);
    run(rlo_pkg::OP_DIV, 16'h0003, 3'h0);
    chk("divo ovf", 16'h0001, {15'h0000, o_overflow});
    chk("divo sec", 16'h0005, o_sec);
    run(rlo_pkg::OP_SKIP_OVF, 16'h0000, 3'h0);
    ld(16'h8000, 16'h0000);
    run(rlo_pkg::OP_DIV, 16'h0001, 3'h0);
    chk("divq ovf", 16'h0001, {15'h0000, o_overflow});
    chk("divq acc", 16'h8000, o_acc);
    run(rlo_pkg::OP_SKIP_OVF, 16'h0000, 3'h0);
    chk("divq skip", 16'h0001, {15'h0000, skp});
    ld(16'h0007, 16'h0000);
    run(rlo_pkg::OP_PARITY, 16'h0000, 3'h0);
    chk("par odd", 16'h0001, {15'h0000, o_rsp.parity});
    chk("par data", 16'h0007, md);
    ld(16'h0003, 16'h0000);
    run(rlo_pkg::OP_PARITY, 16'h0000, 3'h0);
    chk("par even", 16'h0000, {15'h0000, o_rsp.parity});
    $display("test muldiv parity done");
  endtask : t_muldiv
  task automatic t_xfer();
    logic [2:0] ds [3];
    logic [15:0] e;
    ds = '{3'h7, 3'h1, 3'h6};
    for (int i = 16; i <= 26; i++) begin
      foreach (ds[j]) begin
        ld(16'h1234, 16'h0F0F);
        run(rlo_pkg::rlo_op_t'(i[4:0]), 16'hA5C3, ds[j]);
        case (i)
          16: e = 16'hFFFF;
          17: e = 16'h0000;
          18: e = 16'h1234;
          19: e = 16'h0F0F;
          20: e = ~16'h1234;
          21: e = ~16'h0F0F;
          22: e = oc(16'h1234, 16'h0F0F);
          23: e = 16'h1234 ^ 16'h0F0F;
          24: e = 16'h1234 & 16'h0F0F;
          25: e = ~(16'h1234 & 16'h0F0F);
          default: e = 16'hA5C3;
        endcase
        chk("xfer acc", ds[j][0] ? e : 16'h1234, o_acc);
        chk("xfer sec", ds[j][1] ? e : 16'h0F0F, o_sec);
        chk("xfer we", {15'h0000, ds[j][2]}, {15'h0000, we});
        if (ds[j][2]) chk("xfer mem", e, md);
      end
    end
    ld(16'h1234, 16'h0F0F);
    run(rlo_pkg::rlo_op_t'(5'h1B), 16'hA5C3, 3'h7);
    chk("undef acc", 16'h1234, o_acc);
    chk("undef sec", 16'h0F0F, o_sec);
    chk("undef we", 16'h0000, {15'h0000, we});
    $display("test transfer done");
  endtask : t_xfer
  initial begin
    #500000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    t_arith();
    t_ovf();
    t_muldiv();
    t_xfer();
    final_report();
  end
endmodule : tb

`default_nettype wire

// >>> rtl/rlo_datapath.sv
// accumulator / secondary register arithmetic and logic datapath
// assumes the instruction stream holds a request until o_ready, and writes
// o_rsp.mem_data back to the operand location when o_rsp.mem_we pulses
`timescale 1ns/100ps
`default_nettype none

module rlo_datapath (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire rlo_pkg::rlo_req_t i_req,
  output logic o_ready,
  output rlo_pkg::rlo_rsp_t o_rsp,
  output logic [rlo_pkg::DATA_W-1:0] o_acc,
  output logic [rlo_pkg::DATA_W-1:0] o_sec,
  output logic o_overflow
);

  localparam int W = rlo_pkg::DATA_W;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    rlo_pkg::rlo_state_t st;
    logic [W-1:0] acc;
    logic [W-1:0] sec;
    logic ovf;
    logic [rlo_pkg::CNT_W-1:0] cnt;
    logic [W-1:0] mc;
    logic [W-1:0] hi;
    logic [W-1:0] lo;
    logic neg_q;
    logic neg_r;
    rlo_pkg::rlo_rsp_t rsp;
  } rlo_regs_t;

  // reset image: idle, registers clear, no response pending
  // hi:lo is the double-length work pair of multiply and divide
  localparam rlo_regs_t REGS_RST = '{
    st: rlo_pkg::ST_IDLE,
    acc: rlo_pkg::WORD_ZERO,
    sec: rlo_pkg::WORD_ZERO,
    ovf: 1'b0,
    cnt: rlo_pkg::CNT_ZERO,
    mc: rlo_pkg::WORD_ZERO,
    hi: rlo_pkg::WORD_ZERO,
    lo: rlo_pkg::WORD_ZERO,
    neg_q: 1'b0,
    neg_r: 1'b0,
    rsp: '0
  };

  rlo_regs_t regs_ff;
  rlo_regs_t nxt_regs;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // ones' complement add: end-around carry, so minus zero stays distinct
  function automatic logic [W-1:0] oc_add(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W:0] raw;
    raw = {1'b0, a} + {1'b0, b};
    return raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
  endfunction : oc_add

  function automatic logic add_ovf(input logic [W-1:0] a, input logic [W-1:0] b,
                                   input logic [W-1:0] s);
    return (a[W-1] == b[W-1]) && (s[W-1] != a[W-1]);
  endfunction : add_ovf

  // ------------------------------------------------------------
  // sign handling
  // ------------------------------------------------------------
  function automatic logic [W-1:0] mag(input logic [W-1:0] x);
    return x[W-1] ? ~x : x;
  endfunction : mag

  // puts a sign back on a magnitude, ones' complement style
  function automatic logic [W-1:0] apply_sign(input logic [W-1:0] x, input logic neg);
    return x ^ {W{neg}};
  endfunction : apply_sign

  // ------------------------------------------------------------
  // transfer group
  // ------------------------------------------------------------
  // codes above copy_memory_to_dest are unused and must not touch any destination
  function automatic logic is_xfer(input rlo_pkg::rlo_op_t op);
    return (op >= rlo_pkg::OP_ONES) && (op <= rlo_pkg::OP_CPY_MEM);
  endfunction : is_xfer

  // source of the transfer group
  function automatic logic [W-1:0] xfer_src(input rlo_pkg::rlo_op_t op, input logic [W-1:0] a,
                                            input logic [W-1:0] q, input logic [W-1:0] m);
    logic [W-1:0] r;
    r = rlo_pkg::WORD_ZERO;
    unique case (op)
      rlo_pkg::OP_ONES: r = rlo_pkg::WORD_ONES;
      rlo_pkg::OP_ZERO: r = rlo_pkg::WORD_ZERO;
      rlo_pkg::OP_CPY_ACC: r = a;
      rlo_pkg::OP_CPY_SEC: r = q;
      rlo_pkg::OP_CPL_ACC: r = ~a;
      rlo_pkg::OP_CPL_SEC: r = ~q;
      rlo_pkg::OP_SUM_AQ: r = oc_add(a, q);
      rlo_pkg::OP_XOR_AQ: r = a ^ q;
      rlo_pkg::OP_AND_AQ: r = a & q;
      rlo_pkg::OP_NAND_AQ: r = ~(a & q);
      rlo_pkg::OP_CPY_MEM: r = m;
      default: r = rlo_pkg::WORD_ZERO;
    endcase
    return r;
  endfunction : xfer_src

  // ------------------------------------------------------------
  // combinational operands
  // ------------------------------------------------------------
  logic [W-1:0] opnd;
  logic [W-1:0] sum_acc;
  logic [W-1:0] dif_acc;
  logic [W-1:0] sum_sec;
  logic [W-1:0] inc_mem;
  logic [W-1:0] xsrc;
  logic [W:0] mul_part;
  logic [W:0] div_rem;
  logic [W:0] div_try;
  logic [W-1:0] div_hi0;
  logic [W-1:0] div_lo0;
  logic [W-1:0] div_mag;
  logic last_step;
  logic div_ovf;
  logic [W-1:0] mul_hi_nx;
  logic [W-1:0] mul_lo_nx;
  logic [W-1:0] div_hi_nx;
  logic [W-1:0] div_lo_nx;

  assign opnd = i_req.operand;
  assign sum_acc = oc_add(regs_ff.acc, opnd);
  assign dif_acc = oc_add(regs_ff.acc, ~opnd);
  assign sum_sec = oc_add(regs_ff.sec, opnd);
  assign inc_mem = oc_add(opnd, rlo_pkg::WORD_ONE);
  assign xsrc = xfer_src(i_req.op, regs_ff.acc, regs_ff.sec, opnd);

  // ------------------------------------------------------------
  // multiply and divide steps
  // ------------------------------------------------------------
  assign last_step = (regs_ff.cnt == rlo_pkg::CNT_LAST);
  // one add-and-shift step
  assign mul_part = regs_ff.lo[0] ? ({1'b0, regs_ff.hi} + {1'b0, regs_ff.mc})
                                  : {1'b0, regs_ff.hi};
  // the low half shifts out multiplier bits as the product moves in
  assign mul_hi_nx = mul_part[W:1];
  assign mul_lo_nx = {mul_part[0], regs_ff.lo[W-1:1]};
  // one subtract-and-shift step, partial remainder always below divisor
  assign div_rem = {regs_ff.hi, regs_ff.lo[W-1]};
  assign div_try = div_rem - {1'b0, regs_ff.mc};
  // quotient bits enter at the bottom of lo as the dividend leaves the top
  assign div_hi_nx = div_try[W] ? div_rem[W-1:0] : div_try[W-1:0];
  assign div_lo_nx = {regs_ff.lo[W-2:0], ~div_try[W]};
  // dividend magnitude over secondary:accumulator
  assign div_hi0 = regs_ff.sec[W-1] ? ~regs_ff.sec : regs_ff.sec;
  assign div_lo0 = regs_ff.sec[W-1] ? ~regs_ff.acc : regs_ff.acc;
  assign div_mag = mag(opnd);
  // the quotient has only W-1 magnitude bits, so the dividend shifted right by
  // W-1 must stay below the divisor; a zero divisor always lands here too
  assign div_ovf = ({div_hi0, div_lo0[W-1]} >= {1'b0, div_mag});

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.rsp.done = 1'b0;
    nxt_regs.rsp.skip = 1'b0;
    nxt_regs.rsp.mem_we = 1'b0;
    unique case (regs_ff.st)
      rlo_pkg::ST_IDLE: begin
        if (i_req.valid) begin
          nxt_regs.rsp.done = 1'b1;
          if (is_xfer(i_req.op)) begin
            // one result fans out to any mix of destinations
            if (i_req.dest[rlo_pkg::DEST_ACC]) begin
              nxt_regs.acc = xsrc;
            end
            if (i_req.dest[rlo_pkg::DEST_SEC]) begin
              nxt_regs.sec = xsrc;
            end
            if (i_req.dest[rlo_pkg::DEST_MEM]) begin
              nxt_regs.rsp.mem_we = 1'b1;
              nxt_regs.rsp.mem_data = xsrc;
            end
            // the sum transfer is an add as well, so it can overflow
            if (i_req.op == rlo_pkg::OP_SUM_AQ && add_ovf(regs_ff.acc, regs_ff.sec, xsrc)) begin
              nxt_regs.ovf = 1'b1;
            end
          end else begin
            unique case (i_req.op)
              rlo_pkg::OP_AND: nxt_regs.acc = regs_ff.acc & opnd;
              rlo_pkg::OP_XOR: nxt_regs.acc = regs_ff.acc ^ opnd;
              // overflow is sticky until a skip test clears it
              rlo_pkg::OP_ADD, rlo_pkg::OP_INC_ACC: begin
                nxt_regs.acc = sum_acc;
                nxt_regs.ovf = regs_ff.ovf | add_ovf(regs_ff.acc, opnd, sum_acc);
              end
              rlo_pkg::OP_ADD_SEC, rlo_pkg::OP_INC_SEC: begin
                nxt_regs.sec = sum_sec;
                nxt_regs.ovf = regs_ff.ovf | add_ovf(regs_ff.sec, opnd, sum_sec);
              end
              rlo_pkg::OP_SUB: begin
                nxt_regs.acc = dif_acc;
                nxt_regs.ovf = regs_ff.ovf | add_ovf(regs_ff.acc, ~opnd, dif_acc);
              end
              rlo_pkg::OP_RAO: begin
                nxt_regs.rsp.mem_we = 1'b1;
                nxt_regs.rsp.mem_data = inc_mem;
                nxt_regs.ovf = regs_ff.ovf | add_ovf(opnd, rlo_pkg::WORD_ONE, inc_mem);
              end
              rlo_pkg::OP_SKIP_OVF: begin
                nxt_regs.rsp.skip = regs_ff.ovf;
                nxt_regs.ovf = 1'b0;
              end
              rlo_pkg::OP_SKIP_NOVF: begin
                // the test clears the flag, so a repeat sees it clear
                nxt_regs.rsp.skip = ~regs_ff.ovf;
                nxt_regs.ovf = 1'b0;
              end
              rlo_pkg::OP_PARITY: begin
                nxt_regs.rsp.mem_we = 1'b1;
                nxt_regs.rsp.mem_data = regs_ff.acc;
                nxt_regs.rsp.parity = ^regs_ff.acc;
              end
              rlo_pkg::OP_MUL: begin
                // magnitudes only: the sign goes back on at the last step
                nxt_regs.rsp.done = 1'b0;
                nxt_regs.st = rlo_pkg::ST_MUL;
                nxt_regs.cnt = rlo_pkg::CNT_ZERO;
                nxt_regs.mc = mag(opnd);
                nxt_regs.hi = rlo_pkg::WORD_ZERO;
                nxt_regs.lo = mag(regs_ff.acc);
                nxt_regs.neg_q = regs_ff.acc[W-1] ^ opnd[W-1];
              end
              rlo_pkg::OP_DIV: begin
                if (div_ovf) begin
                  // quotient cannot fit (or divisor zero): registers kept
                  nxt_regs.ovf = 1'b1;
                end else begin
                  nxt_regs.rsp.done = 1'b0;
                  nxt_regs.st = rlo_pkg::ST_DIV;
                  nxt_regs.cnt = rlo_pkg::CNT_ZERO;
                  nxt_regs.mc = div_mag;
                  nxt_regs.hi = div_hi0;
                  nxt_regs.lo = div_lo0;
                  nxt_regs.neg_q = regs_ff.sec[W-1] ^ opnd[W-1];
                  nxt_regs.neg_r = regs_ff.sec[W-1];
                end
              end
              // codes without a function only acknowledge
              default: nxt_regs.rsp.done = 1'b1;
            endcase
          end
        end
      end
      rlo_pkg::ST_MUL: begin
        nxt_regs.cnt = regs_ff.cnt + 1'b1;
        nxt_regs.hi = mul_hi_nx;
        nxt_regs.lo = mul_lo_nx;
        if (last_step) begin
          nxt_regs.st = rlo_pkg::ST_IDLE;
          nxt_regs.rsp.done = 1'b1;
          nxt_regs.sec = apply_sign(mul_hi_nx, regs_ff.neg_q);
          nxt_regs.acc = apply_sign(mul_lo_nx, regs_ff.neg_q);
        end
      end
      rlo_pkg::ST_DIV: begin
        nxt_regs.cnt = regs_ff.cnt + 1'b1;
        nxt_regs.hi = div_hi_nx;
        nxt_regs.lo = div_lo_nx;
        if (last_step) begin
          nxt_regs.st = rlo_pkg::ST_IDLE;
          nxt_regs.rsp.done = 1'b1;
          nxt_regs.acc = apply_sign(div_lo_nx, regs_ff.neg_q);
          nxt_regs.sec = apply_sign(div_hi_nx, regs_ff.neg_r);
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      regs_ff <= REGS_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // requests are only taken while idle; multiply/divide hold off the stream
  assign o_ready = (regs_ff.st == rlo_pkg::ST_IDLE);
  assign o_rsp = regs_ff.rsp;
  assign o_acc = regs_ff.acc;
  assign o_sec = regs_ff.sec;
  assign o_overflow = regs_ff.ovf;

endmodule : rlo_datapath

`default_nettype wire

// >>> rtl/rlo_pkg.sv
// package for the accumulator / secondary register arithmetic datapath
// assumes one cpu clock; the instruction stream hands in one decoded op at a time

package rlo_pkg;

  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int DEST_W = 3;

  // destination select bit positions
  localparam int DEST_ACC = 0;
  localparam int DEST_SEC = 1;
  localparam int DEST_MEM = 2;

  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_ONES = 16'hFFFF;
  localparam logic [DATA_W-1:0] WORD_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;

  typedef enum logic [4:0] {
    OP_AND = 5'h00,
    OP_ADD = 5'h01,
    OP_XOR = 5'h02,
    OP_ADD_SEC = 5'h03,
    OP_INC_ACC = 5'h04,
    OP_INC_SEC = 5'h05,
    OP_RAO = 5'h06,
    OP_SUB = 5'h07,
    OP_SKIP_OVF = 5'h08,
    OP_SKIP_NOVF = 5'h09,
    OP_MUL = 5'h0A,
    OP_DIV = 5'h0B,
    OP_PARITY = 5'h0C,
    OP_ONES = 5'h10,
    OP_ZERO = 5'h11,
    OP_CPY_ACC = 5'h12,
    OP_CPY_SEC = 5'h13,
    OP_CPL_ACC = 5'h14,
    OP_CPL_SEC = 5'h15,
    OP_SUM_AQ = 5'h16,
    OP_XOR_AQ = 5'h17,
    OP_AND_AQ = 5'h18,
    OP_NAND_AQ = 5'h19,
    OP_CPY_MEM = 5'h1A
  } rlo_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MUL = 3'b010,
    ST_DIV = 3'b100
  } rlo_state_t;

  typedef struct packed {
    logic valid;
    rlo_op_t op;
    logic [DATA_W-1:0] operand;
    logic [DEST_W-1:0] dest;
  } rlo_req_t;

  typedef struct packed {
    logic done;
    logic skip;
    logic mem_we;
    logic [DATA_W-1:0] mem_data;
    logic parity;
  } rlo_rsp_t;

endpackage : rlo_pkg
